// ---- logic/osel_top.sv ----
/*
 One-second error latch bank: four error counters latched once a
 second by an internal timer and read over the parallel port.
 Assumes error pulses are one cycle wide and synchronous to I_CLK,
 and that the page select is decoded outside into I_PAGE_SEL.
 Holds the timer, one counter slot per error kind and the read path.
 Assumes the reader fetches both halves of a split count within one
 second, since the latches carry no read-side lock.
 Assumes a page read is a one-cycle strobe with a steady address.
*/
// Operation
// - E-bit latched count: top bits at 10H bits 1..0, low byte at 11H.
// - Eight-bit count of errored alignment words, latched value read at 12H.
// - Sixteen-bit bipolar violation latch: high byte 13H, low byte 14H.
// - Each detected line-code violation advances that count by one, holding at full scale.
// - CRC-4 latched count: top bits at 15H bits 1..0, low byte 16H.
// - Every running count copied into its latch on each one-second tick.
`timescale 1ns/1ps
module osel_top
   import osel_pkg::*;
#(
   parameter int SECOND_CYCLES = osel_pkg::OSEL_SECOND_CYC
) (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_EBIT_ERROR,
   input wire logic I_ALIGN_ERROR,
   input wire logic I_BIPOLAR_VIOLATION,
   input wire logic I_CRC4_ERROR,
   input wire logic I_PAGE_SEL,
   input wire logic I_RD,
   input wire logic [4:0] I_ADDR,
   output logic [7:0] O_RDATA,
   output logic O_RDATA_VALID,
   output logic O_SECOND_TICK
);
   import osel_pkg::*;

   // Counter slots: E-bit, alignment word, line code, CRC-4
   localparam int NUM_CNT = 4;
   localparam int SLOT_EBIT = 0;
   localparam int SLOT_ALIGN = 1;
   localparam int SLOT_BIPOLAR = 2;
   localparam int SLOT_CRC = 3;

   // Width of each slot; the widest sets the common latch width
   localparam int CNT_W [NUM_CNT] = '{
      OSEL_EBIT_W,
      OSEL_ALIGN_W,
      OSEL_BIPOLAR_W,
      OSEL_CRC_W
   };
   localparam int LAT_W = OSEL_BIPOLAR_W;

   // Unused top bits of the split 10-bit counts
   localparam logic [5:0] RSVD_BITS = 6'h00;

   // Second timer state
   logic [31:0] tmr;
   logic [31:0] next_tmr;
   logic tick;
   wire tmr_end;

   // Event pulse per slot
   logic [NUM_CNT-1:0] err_event;

   // Latched values, widened to a common width
   logic [LAT_W-1:0] latched [NUM_CNT];

   // Read strobe and next output values
   wire read_taken;
   logic [7:0] next_rdata;
   wire next_valid;
   wire next_tick;

   // One hit per mapped offset
   wire hit_ebit_hi;
   wire hit_ebit_lo;
   wire hit_align;
   wire hit_bipolar_hi;
   wire hit_bipolar_lo;
   wire hit_crc_hi;
   wire hit_crc_lo;
   wire hit_any;

   // Register bytes as software sees them
   wire [7:0] byte_ebit_hi;
   wire [7:0] byte_ebit_lo;
   wire [7:0] byte_align;
   wire [7:0] byte_bipolar_hi;
   wire [7:0] byte_bipolar_lo;
   wire [7:0] byte_crc_hi;
   wire [7:0] byte_crc_lo;

   // Each byte masked by its own hit
   wire [7:0] pick_ebit_hi;
   wire [7:0] pick_ebit_lo;
   wire [7:0] pick_align;
   wire [7:0] pick_bipolar_hi;
   wire [7:0] pick_bipolar_lo;
   wire [7:0] pick_crc_hi;
   wire [7:0] pick_crc_lo;
   wire [7:0] picked;

   // One-second timer: counts 0 to SECOND_CYCLES-1, one-cycle tick at the top
   assign tmr_end = (tmr == 32'(SECOND_CYCLES - 1));
   assign tick = tmr_end;
   assign next_tmr = tmr_end ? 32'h0 : tmr + 32'h1;

   // Timer register
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         tmr <= 32'h0;
      end else begin
         tmr <= next_tmr;
      end
   end

   // Event pulses, one bit per slot
   assign err_event[SLOT_EBIT] = I_EBIT_ERROR;
   assign err_event[SLOT_ALIGN] = I_ALIGN_ERROR;
   assign err_event[SLOT_BIPOLAR] = I_BIPOLAR_VIOLATION;
   assign err_event[SLOT_CRC] = I_CRC4_ERROR;

   // One saturating counter per slot; all share the tick, so the
   // four latches always describe the same second
   for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
      localparam int W = CNT_W[g];
      logic [W-1:0] lat;

      // Counter and latch for this slot
      osel_err_counter #(
         .WIDTH(W)
      ) u_osel_err_counter (
         .i_clk(I_CLK),
         .i_rst_b(I_RST_B),
         .i_event(err_event[g]),
         .i_tick(tick),
         .o_latched(lat)
      );

      // Zero-extend to the common width
      assign latched[g] = LAT_W'(lat);
   end

   // A read counts only while this page is selected
   assign read_taken = I_RD && I_PAGE_SEL;

   // Address decode
   assign hit_ebit_hi = (I_ADDR == OSEL_OFS_EBIT_HI);
   assign hit_ebit_lo = (I_ADDR == OSEL_OFS_EBIT_LO);
   assign hit_align = (I_ADDR == OSEL_OFS_ALIGN_ERR);
   assign hit_bipolar_hi = (I_ADDR == OSEL_OFS_BIPOLAR_HI);
   assign hit_bipolar_lo = (I_ADDR == OSEL_OFS_BIPOLAR_LO);
   assign hit_crc_hi = (I_ADDR == OSEL_OFS_CRC_HI);
   assign hit_crc_lo = (I_ADDR == OSEL_OFS_CRC_LO);

   // Any mapped offset
   assign hit_any = hit_ebit_hi | hit_ebit_lo | hit_align | hit_bipolar_hi
                  | hit_bipolar_lo | hit_crc_hi | hit_crc_lo;

   // Byte layout; reserved top bits of the 10-bit counts read zero
   assign byte_ebit_hi = {RSVD_BITS, latched[SLOT_EBIT][9:8]};
   assign byte_ebit_lo = latched[SLOT_EBIT][7:0];
   assign byte_align = latched[SLOT_ALIGN][7:0];
   assign byte_bipolar_hi = latched[SLOT_BIPOLAR][15:8];
   assign byte_bipolar_lo = latched[SLOT_BIPOLAR][7:0];
   assign byte_crc_hi = {RSVD_BITS, latched[SLOT_CRC][9:8]};
   assign byte_crc_lo = latched[SLOT_CRC][7:0];

   // Masking by hit
   assign pick_ebit_hi = {8{hit_ebit_hi}} & byte_ebit_hi;
   assign pick_ebit_lo = {8{hit_ebit_lo}} & byte_ebit_lo;
   assign pick_align = {8{hit_align}} & byte_align;
   assign pick_bipolar_hi = {8{hit_bipolar_hi}} & byte_bipolar_hi;
   assign pick_bipolar_lo = {8{hit_bipolar_lo}} & byte_bipolar_lo;
   assign pick_crc_hi = {8{hit_crc_hi}} & byte_crc_hi;
   assign pick_crc_lo = {8{hit_crc_lo}} & byte_crc_lo;

   // Only one hit can be true, so the or of the masked bytes selects
   assign picked = pick_ebit_hi
                 | pick_ebit_lo
                 | pick_align
                 | pick_bipolar_hi
                 | pick_bipolar_lo
                 | pick_crc_hi
                 | pick_crc_lo;

   // Offsets with no hit (00H-0FH, 17H-1FH) read the reset byte
   assign next_rdata = hit_any ? picked : OSEL_RST_BYTE;

   // Answer strobe and tick, one cycle after their cause
   assign next_valid = read_taken;
   assign next_tick = tick;

   // Read data: loaded on a taken read, held until the next one
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RDATA <= OSEL_RST_BYTE;
      end else begin
         if (read_taken) begin
            O_RDATA <= next_rdata;
         end
      end
   end

   // Read answer strobe
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RDATA_VALID <= 1'b0;
      end else begin
         O_RDATA_VALID <= next_valid;
      end
   end

   // Tick seen outside at the edge the new latch values become readable
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_SECOND_TICK <= 1'b0;
      end else begin
         O_SECOND_TICK <= next_tick;
      end
   end
endmodule

// ---- logic/osel_pkg.sv ----
/*
 Package for the one-second error latch bank: register offsets,
 counter widths and timer constants.
 Assumes a 100 MHz core clock and a 5-bit register address.
*/
package osel_pkg;
   // Register offsets within the page
   localparam logic [4:0] OSEL_OFS_EBIT_HI = 5'h10;
   localparam logic [4:0] OSEL_OFS_EBIT_LO = 5'h11;
   localparam logic [4:0] OSEL_OFS_ALIGN_ERR = 5'h12;
   localparam logic [4:0] OSEL_OFS_BIPOLAR_HI = 5'h13;
   localparam logic [4:0] OSEL_OFS_BIPOLAR_LO = 5'h14;
   localparam logic [4:0] OSEL_OFS_CRC_HI = 5'h15;
   localparam logic [4:0] OSEL_OFS_CRC_LO = 5'h16;
   // Counter widths
   localparam int OSEL_EBIT_W = 10;
   localparam int OSEL_ALIGN_W = 8;
   localparam int OSEL_BIPOLAR_W = 16;
   localparam int OSEL_CRC_W = 10;
   // Reset value of the latches and read data
   localparam logic [7:0] OSEL_RST_BYTE = 8'h00;
   // One-second timer
   localparam int OSEL_CLK_MHZ = 100;
   localparam int OSEL_SECOND_US = 1000000;
   localparam int OSEL_SECOND_CYC = OSEL_SECOND_US * OSEL_CLK_MHZ;
endpackage

// ---- logic/osel_err_counter.sv ----
/*
 Saturating error counter with a latch that samples the running
 count on the tick and restarts the count at the same edge.
 Assumes single-cycle event and tick pulses in the core clock.
*/
`timescale 1ns/1ps
module osel_err_counter #(
   parameter int WIDTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_event,
   input wire logic i_tick,
   output logic [WIDTH-1:0] o_latched
);
   logic [WIDTH-1:0] run_count;
   logic [WIDTH-1:0] next_run;
   wire at_max = &run_count;

   // Advance by one per event, hold at full scale; tick restarts
   assign next_run = i_tick ? {{(WIDTH-1){1'b0}}, i_event} :
                     (i_event && !at_max) ? run_count + 1'b1 : run_count;

   // Running count and its per-second latch
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         run_count <= '0;
         o_latched <= '0;
      end else begin
         run_count <= next_run;
         if (i_tick) begin
            o_latched <= run_count;
         end
      end
   end
endmodule

// ---- tb/osel_chk.sv ----
/* Port checker for osel_top.
 Assumes a bind into osel_top with its SECOND_CYCLES. */
`timescale 1ns/1ps
module osel_chk #(
   parameter int SECOND_CYCLES = 48
) (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_PAGE_SEL,
   input wire logic I_RD,
   input wire logic [4:0] I_ADDR,
   input wire logic [7:0] O_RDATA,
   input wire logic O_RDATA_VALID,
   input wire logic O_SECOND_TICK
);
   wire logic taken = I_RD && I_PAGE_SEL;
   int gap;
   // Cycles since the last tick output, restarted at one on each tick
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         gap <= 0;
      end else begin
         gap <= O_SECOND_TICK ? 1 : gap + 1;
      end
   end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   // Read answer, top bits and tick spacing
   a_read_answer: assert property (taken |=> O_RDATA_VALID) else $error("no valid");
   a_valid_pulse: assert property (!taken |=> !O_RDATA_VALID) else $error("bad valid");
   a_data_holds: assert property (!taken |=> $stable(O_RDATA)) else $error("data moved");
   a_ebit_top: assert property (taken && I_ADDR == 5'h10 |=> O_RDATA[7:2] == 6'h00)
      else $error("ebit top bits");
   a_crc_top: assert property (taken && I_ADDR == 5'h15 |=> O_RDATA[7:2] == 6'h00)
      else $error("crc top bits");
   a_tick_period: assert property (O_SECOND_TICK == (gap == SECOND_CYCLES))
      else $error("tick period");
   a_tick_single: assert property (O_SECOND_TICK |=> !O_SECOND_TICK) else $error("tick wide");
endmodule
bind osel_top osel_chk #(.SECOND_CYCLES(SECOND_CYCLES)) u_osel_chk (.I_CLK(I_CLK),
   .I_RST_B(I_RST_B), .I_PAGE_SEL(I_PAGE_SEL), .I_RD(I_RD), .I_ADDR(I_ADDR),
   .O_RDATA(O_RDATA), .O_RDATA_VALID(O_RDATA_VALID), .O_SECOND_TICK(O_SECOND_TICK));

// ---- tb/osel_top_tb.sv ----
/* Bench for osel_top: random error bursts and one all-error burst in the second pass, reads after each tick.
 Assumes a 100 MHz clock and a shortened second. */
`timescale 1ns/1ps
module osel_top_tb;
   import osel_pkg::*;
   localparam int SEC = 48;
   logic I_CLK = 1'b0;
   logic I_RST_B = 1'b0;
   logic [3:0] ev = 4'h0;
   logic rd = 1'b0;
   logic sel = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [7:0] rdata;
   logic valid;
   logic tick;
   logic [15:0] cnt [4];
   int num_errors = 0;
   int num_checks = 0;
   osel_top #(.SECOND_CYCLES(SEC)) u_osel_top (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
      .I_EBIT_ERROR(ev[0]), .I_ALIGN_ERROR(ev[1]), .I_BIPOLAR_VIOLATION(ev[2]),
      .I_CRC4_ERROR(ev[3]), .I_PAGE_SEL(sel), .I_RD(rd), .I_ADDR(addr),
      .O_RDATA(rdata), .O_RDATA_VALID(valid), .O_SECOND_TICK(tick));
   initial forever #5 I_CLK = ~I_CLK;
   // Expected byte per offset
   function automatic logic [7:0] exp_byte(input logic [4:0] a);
      case (a)
         OSEL_OFS_EBIT_HI: return {6'h00, cnt[0][9:8]};
         OSEL_OFS_EBIT_LO: return cnt[0][7:0];
         OSEL_OFS_ALIGN_ERR: return cnt[1][7:0];
         OSEL_OFS_BIPOLAR_HI: return cnt[2][15:8];
         OSEL_OFS_BIPOLAR_LO: return cnt[2][7:0];
         OSEL_OFS_CRC_HI: return {6'h00, cnt[3][9:8]};
         OSEL_OFS_CRC_LO: return cnt[3][7:0];
         default: return OSEL_RST_BYTE;
      endcase
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      num_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One read, selected or not
   task automatic rd_reg(input logic [4:0] a, input logic s);
      @(posedge I_CLK) #1;
      rd = 1'b1;
      sel = s;
      addr = a;
      @(posedge I_CLK) #1;
      rd = 1'b0;
      check({7'h00, valid}, {7'h00, s});
      if (s) check(rdata, exp_byte(a));
   endtask
   task automatic wait_tick;
      for (int i = 0; i <= SEC + 2; i++) begin
         @(posedge I_CLK) #1;
         if (tick === 1'b1) return;
      end
      num_errors++;
      conclude();
   endtask
   // Per second: check latches, then a fresh burst
   initial begin
      void'($urandom(32'h4b4f));
      cnt = '{default: 16'h0000};
      repeat (3) @(posedge I_CLK);
      #1 I_RST_B = 1'b1;
      for (int s = 0; s < 5; s++) begin
         wait_tick();
         for (int a = 5'h0f; a <= 5'h17; a++) rd_reg(5'(a), 1'b1);
         rd_reg(OSEL_OFS_ALIGN_ERR, 1'b0);
         cnt = '{default: 16'h0000};
         for (int c = 0; c < 10; c++) begin
            @(posedge I_CLK) #1;
            ev = (s == 1) ? 4'hf : 4'($urandom);
            for (int k = 0; k < 4; k++) cnt[k] += 16'(ev[k]);
         end
         @(posedge I_CLK) #1;
         ev = 4'h0;
      end
      conclude();
   end
endmodule
